// ### rtl/pc_card_defines.svh
// Register offsets, field positions, reset values and counter widths
// Assumes inclusion by bare name from the card timing files
`ifndef PC_CARD_DEFINES_SVH
`define PC_CARD_DEFINES_SVH

`define REG_ADDR_W        8
`define REG_AREA5_OFS     8'h00
`define REG_AREA6_OFS     8'h04

`define UPPER_SPACE_BIT   21
`define LOWER_SPACE_BIT   20
`define TED_MSB           14
`define TED_LSB           11
`define PCW_MSB           10
`define PCW_LSB           7
`define WM_BIT            6
`define TEH_MSB           3
`define TEH_LSB           0

`define TED_RESET         4'h0
`define PCW_RESET         4'ha
`define TEH_RESET         4'h0
`define WM_RESET          1'b0
`define SPACE_RESET       1'b0

`define WAIT_CNT_W        7

`endif

// ### rtl/pc_card_pkg.sv
// Types shared by the card timing block and its helpers
// Assumes pc_card_defines.svh for widths
`include "pc_card_defines.svh"

package pc_card_pkg;

   typedef struct packed {
      logic       upper_space_attribute;
      logic       lower_space_attribute;
      logic [3:0] addr_to_strobe_delay;
      logic [3:0] access_wait_count;
      logic       ext_wait_mask;
      logic [3:0] strobe_to_addr_hold;
   } area_cfg_type;

   typedef struct packed {
      logic write;
      logic area;
      logic card_select_address_bit;
   } access_req_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_EXT_WAIT,
      ST_HOLD
   } cycle_state_type;

endpackage : pc_card_pkg

// ### rtl/wait_code_lut.sv
// Maps the four-bit access wait code to a count of bus cycles
// Assumes a purely combinational use by the access sequencer
`timescale 1ns/1ps
`include "pc_card_defines.svh"

module wait_code_lut (
   input  wire logic [3:0]             code_i,
   output logic      [`WAIT_CNT_W-1:0] cycles_o
);

   // ------------------------------------------------------------
   // Code table
   // ------------------------------------------------------------
   function automatic logic [`WAIT_CNT_W-1:0] wait_cycles(input logic [3:0] c);
      case (c)
         4'h0:    wait_cycles = 7'h03;
         4'h1:    wait_cycles = 7'h06;
         4'h2:    wait_cycles = 7'h09;
         4'h3:    wait_cycles = 7'h0c;
         4'h4:    wait_cycles = 7'h0f;
         4'h5:    wait_cycles = 7'h12;
         4'h6:    wait_cycles = 7'h16;
         4'h7:    wait_cycles = 7'h1a;
         4'h8:    wait_cycles = 7'h1e;
         4'h9:    wait_cycles = 7'h21;
         4'ha:    wait_cycles = 7'h24;
         4'hb:    wait_cycles = 7'h26;
         4'hc:    wait_cycles = 7'h34;
         4'hd:    wait_cycles = 7'h3c;
         4'he:    wait_cycles = 7'h40;
         default: wait_cycles = 7'h50;
      endcase
   endfunction : wait_cycles

   assign cycles_o = wait_cycles(code_i); // [R7]

endmodule : wait_code_lut

// ### rtl/pin_sync3.sv
// Three-stage synchroniser for a level from a pin
// Assumes the pin is asynchronous to clock_i
`timescale 1ns/1ps

module pin_sync3 #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   input  wire logic pin_i,
   output logic      level_o
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   logic agree;

   // Only the second and third stages are compared; first is metastable
   assign agree   = (s2_r == s3_r);
   assign level_o = level_r;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_r    <= RESET_LEVEL;
         s2_r    <= RESET_LEVEL;
         s3_r    <= RESET_LEVEL;
         level_r <= RESET_LEVEL;
      end else begin
         s1_r    <= pin_i;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         level_r <= agree ? s3_r : level_r;
      end
   end

endmodule : pin_sync3

// ### rtl/pc_card_area_timing_config.sv
// Card-interface timing registers for two areas and their access sequencer
// Assumes a plain register port and a bus controller issuing card accesses
//
// What this block does
// R1: Reserved bits 31..22 and 19..15 of each area register read as zero and ignore writes.
// R2: With the card select address bit high, the upper space attribute picks I/O or memory cycles.
// R3: With the card select address bit low, the lower space attribute picks I/O or memory cycles.
// R4: Space attributes only matter while the area is in card interface mode.
// R5: Strobe asserts half a cycle plus the delay field (14..11, reset 0) after the address.
// R6: Software never writes delay codes 1000 and above; the block does not trap them and counts only the low three bits.
// R7: Access wait cycles follow the table 3,6,9,12,15,18,22,26,30,33,36,38,52,60,64,80.
// R8: The wait field sits in 10..7 and resets to 1010, giving 36 cycles.
// R9: The wait mask bit set ignores the external wait input; clear honours it.
// R10: Address holds half a cycle plus the hold field after strobe negation.
// R11: New settings take effect from the next access, never the one in progress.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "pc_card_defines.svh"

module pc_card_area_timing_config (
   input  wire logic                          clock_i,
   input  wire logic                          rst_b_i,
   // Register port
   input  wire logic [`REG_ADDR_W-1:0]        reg_addr_i,
   input  wire logic [31:0]                   reg_wdata_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   output logic      [31:0]                   reg_rdata_o,
   // Access request from the bus controller
   input  wire logic                          acc_req_i,
   input  wire pc_card_pkg::access_req_type   acc_info_i,
   input  wire logic [1:0]                    area_card_mode_i,
   output logic                               acc_busy_o,
   output logic                               acc_done_o,
   // Card side
   input  wire logic                          ext_wait_b_i,
   output logic                               addr_enable_o,
   output logic                               io_cycle_o,
   output logic                               rd_strobe_b_o,
   output logic                               wr_strobe_b_o
);
   import pc_card_pkg::*;

   // ------------------------------------------------------------
   // Field packing
   // ------------------------------------------------------------
   function automatic area_cfg_type cfg_from_word(input logic [31:0] w);
      area_cfg_type c;
      c.upper_space_attribute = w[`UPPER_SPACE_BIT];
      c.lower_space_attribute = w[`LOWER_SPACE_BIT];
      c.addr_to_strobe_delay  = w[`TED_MSB:`TED_LSB];
      c.access_wait_count     = w[`PCW_MSB:`PCW_LSB];
      c.ext_wait_mask         = w[`WM_BIT];
      c.strobe_to_addr_hold   = w[`TEH_MSB:`TEH_LSB];
      return c;
   endfunction : cfg_from_word

   function automatic logic [31:0] word_from_cfg(input area_cfg_type c);
      logic [31:0] w;
      w                      = 32'h0000_0000; // Reserved bits stay zero [R1]
      w[`UPPER_SPACE_BIT]    = c.upper_space_attribute;
      w[`LOWER_SPACE_BIT]    = c.lower_space_attribute;
      w[`TED_MSB:`TED_LSB]   = c.addr_to_strobe_delay;
      w[`PCW_MSB:`PCW_LSB]   = c.access_wait_count;
      w[`WM_BIT]             = c.ext_wait_mask;
      w[`TEH_MSB:`TEH_LSB]   = c.strobe_to_addr_hold;
      return w;
   endfunction : word_from_cfg

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   area_cfg_type cfg5_r;
   area_cfg_type cfg6_r;
   logic [31:0]  rdata_r;
   logic [31:0]  rdata_nxt;
   logic         hit5;
   logic         hit6;

   localparam area_cfg_type CFG_RESET = '{
      upper_space_attribute: `SPACE_RESET,
      lower_space_attribute: `SPACE_RESET,
      addr_to_strobe_delay:  `TED_RESET,     // [R5]
      access_wait_count:     `PCW_RESET,     // [R8]
      ext_wait_mask:         `WM_RESET,
      strobe_to_addr_hold:   `TEH_RESET
   };

   assign hit5 = (reg_addr_i == `REG_AREA5_OFS);
   assign hit6 = (reg_addr_i == `REG_AREA6_OFS);

   // Unmapped or idle reads give zero
   assign rdata_nxt = !reg_rd_i ? 32'h0000_0000 :
                      hit5      ? word_from_cfg(cfg5_r) :
                      hit6      ? word_from_cfg(cfg6_r) : 32'h0000_0000; // [R1]

   assign reg_rdata_o = rdata_r;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg5_r  <= CFG_RESET; // [R8]
         cfg6_r  <= CFG_RESET; // [R8]
         rdata_r <= 32'h0000_0000;
      end else begin
         // Only defined fields are stored; reserved bits drop [R1]
         if (reg_wr_i && hit5) begin
            cfg5_r <= cfg_from_word(reg_wdata_i);
         end
         if (reg_wr_i && hit6) begin
            cfg6_r <= cfg_from_word(reg_wdata_i);
         end
         rdata_r <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   area_cfg_type sel_cfg;
   logic         sel_card;
   logic         sel_space;
   logic         sel_io;

   assign sel_cfg   = acc_info_i.area ? cfg6_r : cfg5_r;
   assign sel_card  = area_card_mode_i[acc_info_i.area];
   assign sel_space = acc_info_i.card_select_address_bit ?
                      sel_cfg.upper_space_attribute :      // [R2]
                      sel_cfg.lower_space_attribute;       // [R3]
   assign sel_io    = sel_card && sel_space;               // [R4]

   // ------------------------------------------------------------
   // External wait pin
   // ------------------------------------------------------------
   logic ext_wait_b_sync;
   logic ext_waiting;

   pin_sync3 #(
      .RESET_LEVEL (1'b1)
   ) u_wait_sync (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .pin_i   (ext_wait_b_i),
      .level_o (ext_wait_b_sync)
   );

   // ------------------------------------------------------------
   // Access sequencer
   // ------------------------------------------------------------
   cycle_state_type        state_r;
   area_cfg_type           act_r;
   logic                   write_r;
   logic                   io_r;
   logic                   addr_en_r;
   logic                   strobe_pos_r;
   logic                   done_r;
   logic [`WAIT_CNT_W-1:0] cnt_r;
   logic [`WAIT_CNT_W-1:0] wait_cycles;
   logic [`WAIT_CNT_W-1:0] ted_cycles;
   logic [`WAIT_CNT_W-1:0] teh_cycles;
   logic                   start;
   logic                   cnt_zero;
   logic                   hold_on_wait;

   wait_code_lut u_wait_lut (
      .code_i   (act_r.access_wait_count),
      .cycles_o (wait_cycles)
   );

   // Prohibited delay codes are not trapped; only the low three bits count
   assign ted_cycles   = {4'h0, sel_cfg.addr_to_strobe_delay[2:0]};     // [R6]
   assign teh_cycles   = {3'h0, act_r.strobe_to_addr_hold};
   assign start        = (state_r == ST_IDLE) && acc_req_i;
   assign cnt_zero     = (cnt_r == 7'h00);
   assign ext_waiting  = !ext_wait_b_sync;
   assign hold_on_wait = ext_waiting && !act_r.ext_wait_mask;            // [R9]

   assign acc_busy_o    = (state_r != ST_IDLE);
   assign acc_done_o    = done_r;
   assign addr_enable_o = addr_en_r;
   assign io_cycle_o    = io_r;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r      <= ST_IDLE;
         act_r        <= CFG_RESET;
         write_r      <= 1'b0;
         io_r         <= 1'b0;
         addr_en_r    <= 1'b0;
         strobe_pos_r <= 1'b0;
         done_r       <= 1'b0;
         cnt_r        <= 7'h00;
      end else begin
         done_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  // Snapshot so later writes do not touch this access
                  act_r     <= sel_cfg;                                   // [R11]
                  write_r   <= acc_info_i.write;
                  io_r      <= sel_io;                                    // [R2] [R3]
                  addr_en_r <= 1'b1;
                  if (ted_cycles == 7'h00) begin
                     strobe_pos_r <= 1'b1;                                // [R5]
                     state_r      <= ST_STROBE;
                     cnt_r        <= 7'h00;
                  end else begin
                     state_r <= ST_SETUP;
                     cnt_r   <= ted_cycles;
                  end
               end
            end
            ST_SETUP: begin
               if (cnt_r == 7'h01) begin
                  strobe_pos_r <= 1'b1;                                   // [R5]
                  state_r      <= ST_STROBE;
                  cnt_r        <= 7'h00;
               end else begin
                  cnt_r <= cnt_r - 7'h01;
               end
            end
            ST_STROBE: begin
               // Count loads on the first strobe cycle from the snapshot
               if (cnt_r == 7'h01 || (cnt_zero && wait_cycles == 7'h00)) begin
                  if (hold_on_wait) begin
                     state_r <= ST_EXT_WAIT;                              // [R9]
                  end else begin
                     strobe_pos_r <= 1'b0;
                     state_r      <= ST_HOLD;
                     cnt_r        <= teh_cycles;
                  end
               end else if (cnt_zero) begin
                  cnt_r <= wait_cycles - 7'h01;                           // [R7]
               end else begin
                  cnt_r <= cnt_r - 7'h01;
               end
            end
            ST_EXT_WAIT: begin
               if (!hold_on_wait) begin
                  strobe_pos_r <= 1'b0;
                  state_r      <= ST_HOLD;
                  cnt_r        <= teh_cycles;
               end
            end
            ST_HOLD: begin
               if (cnt_zero) begin
                  addr_en_r <= 1'b0;                                      // [R10]
                  done_r    <= 1'b1;
                  state_r   <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 7'h01;                                 // [R10]
               end
            end
            default: begin
               state_r      <= ST_IDLE;
               addr_en_r    <= 1'b0;
               strobe_pos_r <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Half-cycle strobe retiming
   // ------------------------------------------------------------
   // Falling-edge stage adds the half cycle to both assert and negate
   logic rd_strobe_b_r;
   logic wr_strobe_b_r;

   assign rd_strobe_b_o = rd_strobe_b_r;
   assign wr_strobe_b_o = wr_strobe_b_r;

   always_ff @(negedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_strobe_b_r <= 1'b1;
         wr_strobe_b_r <= 1'b1;
      end else begin
         rd_strobe_b_r <= !(strobe_pos_r && !write_r);                   // [R5] [R10]
         wr_strobe_b_r <= !(strobe_pos_r && write_r);                    // [R5] [R10]
      end
   end

endmodule : pc_card_area_timing_config

// ### tb/card_partner.sv
// Behavioural card that can stretch an access with its wait pin
// Assumes a pull-up on the wait line, so the pin idles high
`timescale 1ns/1ps

module card_partner (
   input  wire logic       clock_i,
   input  wire logic       rd_strobe_b_i,
   input  wire logic       wr_strobe_b_i,
   input  wire logic [7:0] slow_i,
   output logic            ext_wait_b_o
);
   logic       strobe_r;
   logic [7:0] cnt_r;
   wire        start = strobe_r & ~(rd_strobe_b_i & wr_strobe_b_i);

   initial begin
      strobe_r     = 1'b1;
      cnt_r        = 8'h00;
      ext_wait_b_o = 1'b1;
   end

   // Wait pulled low for slow_i cycles once a strobe falls
   always @(posedge clock_i) begin
      strobe_r <= rd_strobe_b_i & wr_strobe_b_i;
      if (start && slow_i != 8'h00) begin
         cnt_r        <= slow_i;
         ext_wait_b_o <= 1'b0;
      end else if (cnt_r > 8'h01) begin
         cnt_r <= cnt_r - 8'h01;
      end else begin
         cnt_r        <= 8'h00;
         ext_wait_b_o <= 1'b1;
      end
   end
endmodule : card_partner

// ### tb/pc_card_area_timing_config_sva.sv
// Assertions on the card timing block, bound to its top module
// Assumes software keeps the delay top bit clear
`timescale 1ns/1ps
`include "pc_card_defines.svh"

module pc_card_area_timing_config_sva
   import pc_card_pkg::*;
(
   input wire logic                        clock_i,
   input wire logic                        rst_b_i,
   input wire logic [`REG_ADDR_W-1:0]      reg_addr_i,
   input wire logic [31:0]                 reg_wdata_i,
   input wire logic                        reg_wr_i,
   input wire logic                        reg_rd_i,
   input wire logic [31:0]                 reg_rdata_o,
   input wire logic                        acc_req_i,
   input wire pc_card_pkg::access_req_type acc_info_i,
   input wire logic [1:0]                  area_card_mode_i,
   input wire logic                        acc_busy_o,
   input wire logic                        acc_done_o,
   input wire logic                        ext_wait_b_i,
   input wire logic                        addr_enable_o,
   input wire logic                        io_cycle_o,
   input wire logic                        rd_strobe_b_o,
   input wire logic                        wr_strobe_b_o
);
   // ------------------------------
   // Shadow and counters
   // ------------------------------
   localparam int WT [16] = '{3, 6, 9, 12, 15, 18, 22, 26, 30, 33, 36, 38, 52, 60, 64, 80};
   logic [31:0] shadow_r [2];
   logic [31:0] exp_rd_r;
   logic [31:0] cap_r;
   logic        csb_r;
   logic        mode_r;
   logic [8:0]  since_r;
   logic [8:0]  low_r;
   logic [8:0]  post_r;
   wire         strobe_any = rd_strobe_b_o & wr_strobe_b_o;
   wire         take       = acc_req_i & ~acc_busy_o;
   wire         sel6       = reg_addr_i == `REG_AREA6_OFS;
   wire         mapped     = sel6 | (reg_addr_i == `REG_AREA5_OFS);

   // Snapshot at acceptance, so late writes never leak into a running access
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         shadow_r[0] <= 32'h0000_0500;
         shadow_r[1] <= 32'h0000_0500;
         exp_rd_r    <= 32'h0000_0000;
         cap_r       <= 32'h0000_0000;
         csb_r       <= 1'b0;
         mode_r      <= 1'b0;
         since_r     <= 9'h000;
         low_r       <= 9'h000;
         post_r      <= 9'h000;
      end else begin
         if (reg_wr_i && mapped) shadow_r[sel6] <= reg_wdata_i & 32'h0030_7fcf;
         exp_rd_r <= (reg_rd_i && mapped) ? shadow_r[sel6] : 32'h0000_0000;
         if (take) cap_r <= shadow_r[acc_info_i.area];
         if (take) csb_r <= acc_info_i.card_select_address_bit;
         if (take) mode_r <= area_card_mode_i[acc_info_i.area];
         since_r <= take ? 9'h001 : since_r + 9'h001;
         low_r   <= strobe_any ? 9'h000 : low_r + 9'h001;
         post_r  <= strobe_any ? post_r + 9'h001 : 9'h000;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   sequence strobe_end_s;
      $rose(strobe_any);
   endsequence

   readback_a: assert property (reg_rdata_o == exp_rd_r)
      else $error("register read data wrong");
   upper_attr_a: assert property (addr_enable_o && csb_r |->
      io_cycle_o == (mode_r & cap_r[21]))
      else $error("upper half cycle type wrong");
   lower_attr_a: assert property (addr_enable_o && !csb_r |->
      io_cycle_o == (mode_r & cap_r[20]))
      else $error("lower half cycle type wrong");
   no_card_a: assert property (addr_enable_o && !mode_r |-> !io_cycle_o)
      else $error("io cycle outside card mode");
   strobe_delay_a: assert property ($fell(strobe_any) |->
      since_r == {6'h00, cap_r[13:11]} + 9'h001)
      else $error("strobe assert delay wrong");
   wait_masked_a: assert property (strobe_end_s ##0 cap_r[6] |->
      low_r == WT[cap_r[10:7]])
      else $error("strobe width wrong");
   wait_honoured_a: assert property (strobe_end_s ##0 !cap_r[6] |->
      low_r >= WT[cap_r[10:7]])
      else $error("strobe shorter than wait count");
   addr_hold_a: assert property ($fell(addr_enable_o) |->
      post_r == {5'h00, cap_r[3:0]} + 9'h001)
      else $error("address hold wrong");
   done_release_a: assert property (acc_done_o |-> $fell(addr_enable_o) ##1 !acc_done_o)
      else $error("done not tied to release");
   strobe_idle_a: assert property (!addr_enable_o |-> strobe_any)
      else $error("strobe outside address phase");
endmodule : pc_card_area_timing_config_sva

bind pc_card_area_timing_config pc_card_area_timing_config_sva u_sva (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .acc_req_i(acc_req_i),
   .acc_info_i(acc_info_i), .area_card_mode_i(area_card_mode_i), .acc_busy_o(acc_busy_o),
   .acc_done_o(acc_done_o), .ext_wait_b_i(ext_wait_b_i), .addr_enable_o(addr_enable_o),
   .io_cycle_o(io_cycle_o), .rd_strobe_b_o(rd_strobe_b_o), .wr_strobe_b_o(wr_strobe_b_o));

// ### tb/pc_card_area_timing_config_tb_top.sv
// Self-checking bench for the card timing block
// Assumes the checker binds itself and the card model drives the wait pin
`timescale 1ns/1ps
`include "pc_card_defines.svh"

module pc_card_area_timing_config_tb_top;
   import pc_card_pkg::*;
   localparam int WT [16] = '{3, 6, 9, 12, 15, 18, 22, 26, 30, 33, 36, 38, 52, 60, 64, 80};
   logic           clock_i, rst_b_i, reg_wr_i, reg_rd_i, acc_req_i, ext_wait_b_i;
   logic [7:0]     reg_addr_i, slow;
   logic [31:0]    reg_wdata_i, reg_rdata_o;
   access_req_type acc_info_i;
   logic [1:0]     area_card_mode_i;
   logic           acc_busy_o, acc_done_o, addr_enable_o, io_cycle_o;
   logic           rd_strobe_b_o, wr_strobe_b_o;
   int             error_cnt = 0;
   int             checks_done = 0;

   pc_card_area_timing_config u_pc_card_area_timing_config (.clock_i(clock_i),
      .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .acc_req_i(acc_req_i), .acc_info_i(acc_info_i), .area_card_mode_i(area_card_mode_i),
      .acc_busy_o(acc_busy_o), .acc_done_o(acc_done_o), .ext_wait_b_i(ext_wait_b_i),
      .addr_enable_o(addr_enable_o), .io_cycle_o(io_cycle_o),
      .rd_strobe_b_o(rd_strobe_b_o), .wr_strobe_b_o(wr_strobe_b_o));
   card_partner u_card_partner (.clock_i(clock_i), .rd_strobe_b_i(rd_strobe_b_o),
      .wr_strobe_b_i(wr_strobe_b_o), .slow_i(slow), .ext_wait_b_o(ext_wait_b_i));

   // ------------------------------
   // Checks and bus tasks
   // ------------------------------
   task automatic end_of_test;
      $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
      end
   endtask : chk

   task automatic chk_rng(input string n, input int lo, input int hi, input int g);
      checks_done++;
      if (g < lo || g > hi) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask : chk_rng

   function automatic logic [31:0] mk(input logic s1, s0, input logic [3:0] d, p,
                                      input logic m, input logic [3:0] h);
      return {10'h000, s1, s0, 5'h00, d, p, m, 2'h0, h};
   endfunction : mk

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask : reg_wr

   task automatic reg_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge clock_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 chk(n, e, reg_rdata_o);
   endtask : reg_chk

   // Counts address-only, strobe-low and hold cycles of one access
   task automatic access(input logic w, a, cs, io, input int d, lo, hi, h);
      int   pre = 0;
      int   low = 0;
      int   post = 0;
      int   k;
      logic io_s;
      @(posedge clock_i);
      acc_req_i  <= 1'b1;
      acc_info_i <= '{w, a, cs};
      @(posedge clock_i);
      acc_req_i <= 1'b0;
      #1 io_s = io_cycle_o;
      chk("busy", 32'h1, {31'h0, acc_busy_o});
      for (k = 0; k < 400 && acc_done_o !== 1'b1; k++) begin
         if ((w ? rd_strobe_b_o : wr_strobe_b_o) !== 1'b1) low = 999;
         else if ((w ? wr_strobe_b_o : rd_strobe_b_o) === 1'b0) low++;
         else if (low == 0) pre++;
         else post++;
         @(posedge clock_i);
         #1;
      end
      if (k == 400) begin
         error_cnt++;
         end_of_test();
      end
      chk("io_cycle", {31'h0, io}, {31'h0, io_s});
      chk("setup", d + 1, pre);
      chk_rng("strobe_low", lo, hi, low);
      chk("hold", h, post);
   endtask : access

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_regs;
      reg_chk("area5_rst", `REG_AREA5_OFS, 32'h0000_0500);
      reg_chk("area6_rst", `REG_AREA6_OFS, 32'h0000_0500);
      reg_wr(`REG_AREA5_OFS, 32'hffff_bfff);
      reg_wr(8'h08, 32'h0000_0f00);
      reg_chk("area5_rsvd", `REG_AREA5_OFS, 32'h0030_3fcf);
      reg_chk("unmapped", 8'h08, 32'h0000_0000);
      reg_chk("area6_keep", `REG_AREA6_OFS, 32'h0000_0500);
   endtask : t_regs

   task automatic t_timing;
      for (int c = 0; c < 16; c++) begin
         reg_wr(`REG_AREA5_OFS, mk(0, 0, 4'(c % 8), 4'(c), 1'b1, 4'(15 - c)));
         access(c[0], 0, 0, 0, c % 8, WT[c], WT[c], 15 - c);
      end
   endtask : t_timing

   task automatic t_attr;
      for (int i = 0; i < 16; i++) begin
         reg_wr(`REG_AREA6_OFS, mk(i[2], i[1], 4'h0, 4'h0, 1'b1, 4'h0));
         area_card_mode_i <= {i[3], 1'b1};
         access(i[1], 1, i[0], i[3] & (i[0] ? i[2] : i[1]), 0, 3, 3, 0);
      end
   endtask : t_attr

   task automatic t_wait;
      slow <= 8'h14;
      reg_wr(`REG_AREA5_OFS, mk(0, 0, 4'h1, 4'h1, 1'b0, 4'h2));
      access(0, 0, 0, 0, 1, 20, 28, 2);
      reg_wr(`REG_AREA5_OFS, mk(0, 0, 4'h1, 4'h1, 1'b1, 4'h2));
      access(1, 0, 0, 0, 1, 6, 6, 2);
      slow <= 8'h00;
      // Card's last wait pulse must clear the synchroniser first
      repeat (16) @(posedge clock_i);
      reg_wr(`REG_AREA5_OFS, mk(0, 0, 4'h0, 4'h0, 1'b0, 4'h0));
      access(0, 0, 0, 0, 0, 3, 3, 0);
   endtask : t_wait

   // Rewrite and a refused request while an access runs
   task automatic t_update;
      reg_wr(`REG_AREA5_OFS, mk(0, 0, 4'h2, 4'h3, 1'b1, 4'h4));
      fork
         access(0, 0, 0, 0, 2, 12, 12, 4);
         begin
            repeat (4) @(posedge clock_i);
            reg_wr(`REG_AREA5_OFS, mk(0, 0, 4'h5, 4'h0, 1'b1, 4'h1));
            acc_req_i <= 1'b1;
            @(posedge clock_i);
            acc_req_i <= 1'b0;
         end
      join
      access(1, 0, 0, 0, 5, 3, 3, 1);
   endtask : t_update

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   initial begin
      rst_b_i          = 1'b0;
      reg_wr_i         = 1'b0;
      reg_rd_i         = 1'b0;
      acc_req_i        = 1'b0;
      reg_addr_i       = 8'h00;
      reg_wdata_i      = 32'h0000_0000;
      acc_info_i       = '0;
      area_card_mode_i = 2'h3;
      slow             = 8'h00;
      repeat (16) @(posedge clock_i);
      rst_b_i <= 1'b1;
      t_regs();
      t_timing();
      t_attr();
      t_wait();
      t_update();
      end_of_test();
   end
endmodule : pc_card_area_timing_config_tb_top
